// ### src/bllc_top.sv
// Operation
// - proportional factor equals (code + 1) times 0.05, 0.05 to 0.8.
// - integral factor equals (code + 1) times 0.005, 0.005 to 0.08.
// - slope codes 0,1,2,4,8 select 112,84,70,56,28 kOhm equivalents.
// - sense resistor codes 00..11 select 250, 500, 1000, 1500 ohms.
// - target code zero turns output off; else 0.3606 V per step.
// - gate stops toggling while output exceeds overvoltage limit, resumes below.
// - overvoltage limit 0.3606 V per step; code zero turns output off.
// - peak current reached forces gate off until next cycle start.
// - slope compensation stays active during peak current limiting.
// - peak threshold equals code*1.8V/256 - 0.24V; code zero allows no current.
`timescale 1ns/1ns
module bllc_top (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register port from the serial control interface
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // analog comparator results and switching timing
   input wire logic i_overvoltage_cmp,
   input wire logic i_peak_current_cmp,
   input wire logic i_cycle_start,
   input wire logic i_gate_request,
   // decoded configuration for the analog loop
   output logic [6:0] o_prop_factor_hundredths,
   output logic [6:0] o_integ_factor_thousandths,
   output logic [6:0] o_slope_comp_kohm,
   output logic o_slope_comp_code_valid,
   output logic o_slope_comp_active,
   output logic [10:0] o_sense_resistor_ohm,
   output logic [19:0] o_target_voltage_tenth_mv,
   output logic [19:0] o_overvoltage_limit_tenth_mv,
   output logic signed [21:0] o_peak_threshold_uv,
   output logic o_output_enable,
   output logic o_peak_limited,
   output logic o_gate
);
   import bllc_pkg::*;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] output_target_voltage;
   logic [7:0] output_overvoltage_limit;
   logic [7:0] coil_peak_current_limit;
   logic [GAIN_CODE_W-1:0] proportional_gain_code;
   logic [GAIN_CODE_W-1:0] integral_gain_code;
   logic [SLOPE_CODE_W-1:0] slope_comp_code;
   logic [SENSE_RES_CODE_W-1:0] sense_resistor_code;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         output_target_voltage <= RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == ADDR_OUTPUT_TARGET_VOLTAGE) begin
         output_target_voltage <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         output_overvoltage_limit <= RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == ADDR_OUTPUT_OVERVOLTAGE_LIMIT) begin
         output_overvoltage_limit <= i_reg_wdata;
      end
   end

   // codes above 0x80 are stored as written; keeping them legal is the host's job
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         coil_peak_current_limit <= RST_BYTE;
      end else if (i_reg_wr && i_reg_addr == ADDR_COIL_PEAK_CURRENT_LIMIT) begin
         coil_peak_current_limit <= i_reg_wdata;
      end
   end

   // reserved upper bits are not stored, so they always read back as zero
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         proportional_gain_code <= RST_NIBBLE;
      end else if (i_reg_wr && i_reg_addr == ADDR_LOOP_PROPORTIONAL_GAIN) begin
         proportional_gain_code <= i_reg_wdata[GAIN_CODE_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         integral_gain_code <= RST_NIBBLE;
      end else if (i_reg_wr && i_reg_addr == ADDR_LOOP_INTEGRAL_GAIN) begin
         integral_gain_code <= i_reg_wdata[GAIN_CODE_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         slope_comp_code <= RST_NIBBLE;
      end else if (i_reg_wr && i_reg_addr == ADDR_SLOPE_COMPENSATION_SELECT) begin
         slope_comp_code <= i_reg_wdata[SLOPE_CODE_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sense_resistor_code <= RST_SENSE_RES;
      end else if (i_reg_wr && i_reg_addr == ADDR_SENSE_SLOPE_RESISTOR) begin
         sense_resistor_code <= i_reg_wdata[SENSE_RES_CODE_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // read-back
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      if (i_reg_addr == ADDR_OUTPUT_TARGET_VOLTAGE) begin
         next_rdata = output_target_voltage;
      end else if (i_reg_addr == ADDR_OUTPUT_OVERVOLTAGE_LIMIT) begin
         next_rdata = output_overvoltage_limit;
      end else if (i_reg_addr == ADDR_COIL_PEAK_CURRENT_LIMIT) begin
         next_rdata = coil_peak_current_limit;
      end else if (i_reg_addr == ADDR_LOOP_PROPORTIONAL_GAIN) begin
         next_rdata = {4'h0, proportional_gain_code};
      end else if (i_reg_addr == ADDR_LOOP_INTEGRAL_GAIN) begin
         next_rdata = {4'h0, integral_gain_code};
      end else if (i_reg_addr == ADDR_SLOPE_COMPENSATION_SELECT) begin
         next_rdata = {4'h0, slope_comp_code};
      end else if (i_reg_addr == ADDR_SENSE_SLOPE_RESISTOR) begin
         next_rdata = {6'h00, sense_resistor_code};
      end else begin
         next_rdata = READ_UNMAPPED;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_reg_rdata <= RST_BYTE;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // loop factor decode
   // ----------------------------------------------------------------
   // factors leave in fixed point so the loop needs no divider
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_prop_factor_hundredths <= GAIN_STEP;
         o_integ_factor_thousandths <= GAIN_STEP;
      end else begin
         o_prop_factor_hundredths <= 7'(({3'h0, proportional_gain_code} + 7'h01) * GAIN_STEP);
         o_integ_factor_thousandths <= 7'(({3'h0, integral_gain_code} + 7'h01) * GAIN_STEP);
      end
   end

   // ----------------------------------------------------------------
   // slope compensation and sense resistor decode
   // ----------------------------------------------------------------
   logic [6:0] next_slope_kohm;
   logic next_slope_valid;
   logic [10:0] next_sense_ohm;

   // undefined slope codes fall back to the weakest setting and flag it
   always_comb begin
      next_slope_valid = 1'b1;
      case (slope_comp_code)
         SLOPE_CODE_112K: next_slope_kohm = SLOPE_112K;
         SLOPE_CODE_84K: next_slope_kohm = SLOPE_84K;
         SLOPE_CODE_70K: next_slope_kohm = SLOPE_70K;
         SLOPE_CODE_56K: next_slope_kohm = SLOPE_56K;
         SLOPE_CODE_28K: next_slope_kohm = SLOPE_28K;
         default: begin
            next_slope_kohm = SLOPE_112K;
            next_slope_valid = 1'b0;
         end
      endcase
   end

   always_comb begin
      case (sense_resistor_code)
         2'h0: next_sense_ohm = SENSE_RES_250;
         2'h1: next_sense_ohm = SENSE_RES_500;
         2'h2: next_sense_ohm = SENSE_RES_1000;
         default: next_sense_ohm = SENSE_RES_1500;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_slope_comp_kohm <= SLOPE_112K;
         o_slope_comp_code_valid <= 1'b1;
         o_sense_resistor_ohm <= SENSE_RES_250;
      end else begin
         o_slope_comp_kohm <= next_slope_kohm;
         o_slope_comp_code_valid <= next_slope_valid;
         o_sense_resistor_ohm <= next_sense_ohm;
      end
   end

   // ----------------------------------------------------------------
   // voltage and peak current thresholds
   // ----------------------------------------------------------------
   logic [28:0] peak_product;

   assign peak_product = 29'(coil_peak_current_limit) * 29'(PEAK_FULL_SCALE_UV);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_target_voltage_tenth_mv <= 20'h00000;
         o_overvoltage_limit_tenth_mv <= 20'h00000;
         o_peak_threshold_uv <= 22'sh000000;
      end else begin
         o_target_voltage_tenth_mv <= 20'(output_target_voltage) * 20'(VOLT_STEP_TENTH_MV);
         o_overvoltage_limit_tenth_mv <= 20'(output_overvoltage_limit) * 20'(VOLT_STEP_TENTH_MV);
         // negative for small codes; the comparator then trips at once
         o_peak_threshold_uv <= signed'(22'(peak_product >> PEAK_SHIFT) - PEAK_OFFSET_UV);
      end
   end

   // ----------------------------------------------------------------
   // output enable
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_output_enable <= 1'b0;
      end else begin
         o_output_enable <= (output_target_voltage != 8'h00)
            && (output_overvoltage_limit != 8'h00);
      end
   end

   // ----------------------------------------------------------------
   // comparator synchronisers
   // ----------------------------------------------------------------
   logic overvoltage_sync;
   logic peak_current_sync;

   bllc_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync_ov (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async(i_overvoltage_cmp),
      .o_sync(overvoltage_sync)
   );

   bllc_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync_peak (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async(i_peak_current_cmp),
      .o_sync(peak_current_sync)
   );

   // ----------------------------------------------------------------
   // peak current latch
   // ----------------------------------------------------------------
   // a trip in the same cycle as the cycle start wins over the clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_peak_limited <= 1'b0;
      end else if (peak_current_sync) begin
         o_peak_limited <= 1'b1;
      end else if (i_cycle_start) begin
         o_peak_limited <= 1'b0;
      end
   end

   // limiting never mutes the ramp, otherwise subharmonics appear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_slope_comp_active <= 1'b0;
      end else begin
         o_slope_comp_active <= o_output_enable;
      end
   end

   // ----------------------------------------------------------------
   // gate gating
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_gate <= 1'b0;
      end else begin
         o_gate <= i_gate_request
            && o_output_enable
            && !overvoltage_sync
            && !o_peak_limited
            && !peak_current_sync
            && (coil_peak_current_limit != 8'h00);
      end
   end

endmodule

// ### src/bllc_pkg.sv
package bllc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OUTPUT_TARGET_VOLTAGE = 8'h03;
   localparam logic [7:0] ADDR_OUTPUT_OVERVOLTAGE_LIMIT = 8'h05;
   localparam logic [7:0] ADDR_COIL_PEAK_CURRENT_LIMIT = 8'h07;
   localparam logic [7:0] ADDR_LOOP_PROPORTIONAL_GAIN = 8'h11;
   localparam logic [7:0] ADDR_LOOP_INTEGRAL_GAIN = 8'h12;
   localparam logic [7:0] ADDR_SLOPE_COMPENSATION_SELECT = 8'h13;
   localparam logic [7:0] ADDR_SENSE_SLOPE_RESISTOR = 8'h14;

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int GAIN_CODE_W = 4;
   localparam int SLOPE_CODE_W = 4;
   localparam int SENSE_RES_CODE_W = 2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [1:0] RST_SENSE_RES = 2'h0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // decode scales
   // ----------------------------------------------------------------
   // proportional factor in hundredths: (code + 1) * 5
   // integral factor in thousandths: (code + 1) * 5
   localparam logic [6:0] GAIN_STEP = 7'h05;
   // output voltage in units of 0.1 mV per code step (0.3606 V)
   localparam logic [11:0] VOLT_STEP_TENTH_MV = 12'he16;
   // peak threshold in microvolts: code * 1800000 / 256 - 240000
   localparam logic [20:0] PEAK_FULL_SCALE_UV = 21'h1b7740;
   localparam logic [21:0] PEAK_OFFSET_UV = 22'h03a980;
   localparam int PEAK_SHIFT = 8;

   // slope compensation equivalents in kOhm
   localparam logic [3:0] SLOPE_CODE_112K = 4'h0;
   localparam logic [3:0] SLOPE_CODE_84K = 4'h1;
   localparam logic [3:0] SLOPE_CODE_70K = 4'h2;
   localparam logic [3:0] SLOPE_CODE_56K = 4'h4;
   localparam logic [3:0] SLOPE_CODE_28K = 4'h8;
   localparam logic [6:0] SLOPE_112K = 7'h70;
   localparam logic [6:0] SLOPE_84K = 7'h54;
   localparam logic [6:0] SLOPE_70K = 7'h46;
   localparam logic [6:0] SLOPE_56K = 7'h38;
   localparam logic [6:0] SLOPE_28K = 7'h1c;

   // sense slope resistor in ohms
   localparam logic [10:0] SENSE_RES_250 = 11'h0fa;
   localparam logic [10:0] SENSE_RES_500 = 11'h1f4;
   localparam logic [10:0] SENSE_RES_1000 = 11'h3e8;
   localparam logic [10:0] SENSE_RES_1500 = 11'h5dc;

   // synchroniser depth for comparator pins
   localparam int SYNC_STAGES = 2;

endpackage

// ### src/bllc_sync.sv
`timescale 1ns/1ns
module bllc_sync #(
   parameter int STAGES = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_sync
);

   logic [STAGES-1:0] chain;

   // only the last stage is read; the first stage may be metastable
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], i_async};
      end
   end

   assign o_sync = chain[STAGES-1];

endmodule

// ### bench/bllc_top_sva.sv
`timescale 1ns/1ns
module bllc_top_sva (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic o_reg_rvalid,
   input wire logic i_overvoltage_cmp,
   input wire logic i_peak_current_cmp,
   input wire logic [6:0] o_prop_factor_hundredths,
   input wire logic [6:0] o_integ_factor_thousandths,
   input wire logic [10:0] o_sense_resistor_ohm,
   input wire logic [19:0] o_target_voltage_tenth_mv,
   input wire logic o_slope_comp_active,
   input wire logic o_output_enable,
   input wire logic o_peak_limited,
   input wire logic o_gate
);
   // ----------
   // properties
   // ----------
   localparam logic [10:0] OHM [4] = '{11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // decoded outputs lag the write edge by two samples
   sequence wr_at(logic [7:0] a); i_reg_wr && i_reg_addr == a; endsequence
   // two sync flops plus the gate register: three samples high must reach the gate
   sequence ov_held; i_overvoltage_cmp [*3]; endsequence
   sequence pk_held; i_peak_current_cmp [*3]; endsequence
   chk_read_answer:
      assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   chk_answer_cause:
      assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("answer without read");
   chk_prop_scale:
      assert property (wr_at(8'h11) |-> ##2 o_prop_factor_hundredths == (7'($past(i_reg_wdata[3:0], 2)) + 7'h01) * 7'h05)
      else $error("proportional factor wrong");
   chk_integ_scale:
      assert property (wr_at(8'h12) |-> ##2 o_integ_factor_thousandths == (7'($past(i_reg_wdata[3:0], 2)) + 7'h01) * 7'h05)
      else $error("integral factor wrong");
   chk_sense_select:
      assert property (wr_at(8'h14) |-> ##2 o_sense_resistor_ohm == OHM[$past(i_reg_wdata[1:0], 2)])
      else $error("sense resistor wrong");
   chk_target_scale:
      assert property (wr_at(8'h03) |-> ##2 o_target_voltage_tenth_mv == 20'($past(i_reg_wdata, 2)) * 20'he16)
      else $error("target voltage wrong");
   chk_zero_code_off:
      assert property (i_reg_wr && i_reg_wdata == 8'h00 && (i_reg_addr == 8'h03 || i_reg_addr == 8'h05)
         |-> ##2 !o_output_enable) else $error("output not off");
   chk_ov_gate_stop:
      assert property (ov_held |=> !o_gate) else $error("gate toggles in overvoltage");
   chk_peak_gate_off:
      assert property (pk_held |=> o_peak_limited && !o_gate) else $error("peak limit not taken");
   chk_slope_stays_on:
      assert property (o_peak_limited && $past(o_output_enable) |-> o_slope_comp_active) else $error("slope comp dropped");
endmodule

bind bllc_top bllc_top_sva chk (.i_ref_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rvalid,
   .i_overvoltage_cmp, .i_peak_current_cmp, .o_prop_factor_hundredths, .o_integ_factor_thousandths,
   .o_sense_resistor_ohm, .o_target_voltage_tenth_mv, .o_slope_comp_active, .o_output_enable,
   .o_peak_limited, .o_gate);

// ### bench/bllc_host_model.sv
`timescale 1ns/1ns
module bllc_host_model (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata
);
   // ----------
   // host tasks
   // ----------
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
   end
   // released lines show the inverse so stale values are never mistaken for data
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_reg_wr = 1'b1;
      o_reg_addr = a;
      o_reg_wdata = d;
      @(negedge i_ref_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask
   task automatic write_cfg(input logic [7:0] a, input logic [7:0] d);
      d = d & ((a inside {8'h11, 8'h12, 8'h13}) ? 8'h0f : (a == 8'h14) ? 8'h03 : 8'hff);
      if (a == 8'h07 && d > 8'h80) d = 8'h80;
      write_reg(a, d);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge i_ref_clk);
      o_reg_rd = 1'b1;
      o_reg_addr = a;
      @(negedge i_ref_clk);
      // the answer stands for one cycle only, so take it before the strobe drops
      v = i_reg_rvalid;
      d = i_reg_rdata;
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
   endtask
endmodule

// ### bench/boost_loop_limit_config_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("MISMATCH at %0t: got %0h expected %0h", $time, (g), (e)); \
   end \
end
module boost_loop_limit_config_test;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_overvoltage_cmp = 1'b0;
   logic i_peak_current_cmp = 1'b0;
   logic i_cycle_start = 1'b0;
   logic i_gate_request = 1'b0;
   logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_slope_comp_code_valid, o_slope_comp_active;
   logic o_output_enable, o_peak_limited, o_gate;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [6:0] o_prop_factor_hundredths, o_integ_factor_thousandths, o_slope_comp_kohm;
   logic [10:0] o_sense_resistor_ohm;
   logic [19:0] o_target_voltage_tenth_mv, o_overvoltage_limit_tenth_mv;
   logic signed [21:0] o_peak_threshold_uv;
   int num_errors = 0;
   int total_checks = 0;
   logic [7:0] regs [7] = '{8'h03, 8'h05, 8'h07, 8'h11, 8'h12, 8'h13, 8'h14};
   logic [3:0] sc [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
   logic [6:0] sk [6] = '{7'h70, 7'h54, 7'h46, 7'h38, 7'h1c, 7'h70};
   logic [10:0] ohm [4] = '{11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};

   bllc_top dut (.*);
   bllc_host_model host (.i_ref_clk, .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
      .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));

   // ----------
   // helpers
   // ----------
   function automatic logic [6:0] gain(input int c);
      return 7'((c + 1) * 5);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.read_reg(a, d, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------
   // stimulus
   // ----------
   initial begin
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      logic [7:0] t;
      logic [7:0] l;
      int e;
      void'($urandom(32'h677629b0));
      tick(10);
      i_rst = 1'b0;
      foreach (regs[k]) rd_chk(regs[k], 8'h00);
      `CHK({o_prop_factor_hundredths, o_slope_comp_kohm, o_sense_resistor_ohm}, {7'h05, 7'h70, 11'h0fa})
      for (int k = 0; k < 16; k++) begin
         host.write_cfg(8'h11, 8'(k));
         host.write_cfg(8'h12, 8'(15 - k));
         rd_chk(8'h11, 8'(k));
         `CHK(o_prop_factor_hundredths, gain(k))
         `CHK(o_integ_factor_thousandths, gain(15 - k))
      end
      foreach (sc[k]) begin
         host.write_cfg(8'h13, {4'h0, sc[k]});
         rd_chk(8'h13, {4'h0, sc[k]});
         `CHK({o_slope_comp_kohm, o_slope_comp_code_valid}, {sk[k], k < 5})
      end
      for (int k = 0; k < 4; k++) begin
         host.write_reg(8'h14, 8'hfc | 8'(k));
         rd_chk(8'h14, 8'(k));
         `CHK(o_sense_resistor_ohm, ohm[k])
      end
      for (int k = 0; k < 12; k++) begin
         t = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom_range(1, 240));
         l = (k == 2) ? 8'h00 : (t > 8'hf1) ? 8'hff : t + 8'h0e;
         host.write_cfg(8'h03, t);
         host.write_cfg(8'h05, l);
         rd_chk(8'h05, l);
         `CHK(o_target_voltage_tenth_mv, 20'(t) * 20'he16)
         `CHK(o_overvoltage_limit_tenth_mv, 20'(l) * 20'he16)
         `CHK(o_output_enable, t != 8'h00 && l != 8'h00)
      end
      for (int k = 0; k < 8; k++) begin
         t = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom_range(0, 128));
         host.write_cfg(8'h07, t);
         rd_chk(8'h07, t);
         e = int'(t) * 1800000 / 256 - 240000;
         `CHK(o_peak_threshold_uv, 22'(e))
      end
      repeat (4) rd_chk(8'($urandom_range(32, 255)), 8'h00);
      host.write_cfg(8'h03, 8'h80);
      host.write_cfg(8'h05, 8'h8e);
      host.write_cfg(8'h07, 8'h60);
      i_gate_request = 1'b1;
      tick(4);
      `CHK(o_gate, 1'b1)
      i_overvoltage_cmp = 1'b1;
      tick(4);
      `CHK(o_gate, 1'b0)
      i_overvoltage_cmp = 1'b0;
      tick(4);
      `CHK(o_gate, 1'b1)
      i_peak_current_cmp = 1'b1;
      tick(3);
      i_peak_current_cmp = 1'b0;
      tick(4);
      `CHK({o_peak_limited, o_gate, o_slope_comp_active}, 3'b101)
      i_cycle_start = 1'b1;
      tick(1);
      i_cycle_start = 1'b0;
      tick(3);
      `CHK({o_peak_limited, o_gate}, 2'b01)
      i_peak_current_cmp = 1'b1;
      i_cycle_start = 1'b1;
      tick(4);
      `CHK(o_peak_limited, 1'b1)
      i_peak_current_cmp = 1'b0;
      i_cycle_start = 1'b0;
      host.write_cfg(8'h07, 8'h00);
      tick(3);
      `CHK(o_gate, 1'b0)
      results();
   end
endmodule
